// >>> rtl/flr_regs.sv
// Operating control and flash trigger registers with mode and flash sequencing
`timescale 1ns/1ns
`default_nettype none
module flr_regs
    import flr_pkg::*;
#(
    parameter int FLASH_CYCLES = FLASH_TIME_CYC
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic REG_WE_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic [7:0] LED_CURRENT_I,
    input wire logic [PWM_DUTY_W-1:0] INDICATOR_DUTY_I,
    input wire logic [1:0] EXT_TORCH_SEL_I,
    input wire logic TRIGGER_I,
    output logic SINK_EN_O,
    output logic [7:0] LED_CODE_O,
    output logic LED_ACTIVE_O,
    output logic EXT_TORCH_O,
    output logic FLASH_ACTIVE_O
);
    localparam int FC_W = $clog2(FLASH_CYCLES + 1);

    if (FLASH_CYCLES < 2) begin : g_flash_check
        $error("Flash duration must be at least two cycles");
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic sink_en_reg;
    logic sink_en_next;
    logic trig_type_reg;
    logic trig_en_reg;
    logic [5:0] trig_low_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    wire wr_ctrl = REG_WE_I && (REG_ADDR_I == ADDR_OPERATING_CONTROL);
    wire wr_trig = REG_WE_I && (REG_ADDR_I == ADDR_FLASH_TRIGGER_CONFIG);

    ////////////////////////////////////////////////////////////////////////
    // Flash sequencing
    flr_flash_state_t state_reg;
    flr_flash_state_t state_next;
    logic [FC_W-1:0] fcnt_reg;
    logic [FC_W-1:0] fcnt_next;
    logic trig_prev_reg;

    wire flash_sel = (mode_reg == MODE_FLASH) && sink_en_reg;
    wire trig_rise = TRIGGER_I && !trig_prev_reg;
    // Trigger only acts while flash mode is selected and the input is enabled
    wire trig_start = trig_type_reg ? TRIGGER_I : trig_rise;
    wire flash_start = flash_sel && (trig_en_reg ? trig_start : 1'b1);
    wire flash_timeout = (32'(fcnt_reg) >= 32'(FLASH_CYCLES - 1));
    wire level_drop = trig_en_reg && trig_type_reg && !TRIGGER_I;
    wire flash_end = (state_reg == FS_FLASH) && (flash_timeout || level_drop);

    always_comb begin
        state_next = state_reg;
        fcnt_next = fcnt_reg;
        case (state_reg)
            FS_IDLE: begin
                fcnt_next = '0;
                if (flash_start) begin
                    state_next = FS_FLASH;
                end
            end
            FS_FLASH: begin
                fcnt_next = fcnt_reg + 1'b1;
                if (flash_end || !flash_sel) begin
                    state_next = FS_IDLE;
                    fcnt_next = '0;
                end
            end
            default: begin
                state_next = FS_IDLE;
                fcnt_next = '0;
            end
        endcase
    end

    // A host write in the same cycle as the self clear takes precedence
    assign mode_next = wr_ctrl ? REG_WDATA_I[CTRL_MODE_LSB+:2] :
                       flash_end ? MODE_SHUTDOWN : mode_reg;
    assign sink_en_next = wr_ctrl ? REG_WDATA_I[CTRL_SINK_EN_BIT] :
                          flash_end ? 1'b0 : sink_en_reg;

    // Reserved control bit reads as zero; write data there is dropped
    wire [7:0] ctrl_rd = {4'h0, sink_en_reg, 1'b0, mode_reg};
    wire [7:0] trig_rd = {trig_en_reg, trig_type_reg, trig_low_reg};
    assign rdata_next = (REG_ADDR_I == ADDR_OPERATING_CONTROL) ? ctrl_rd :
                        (REG_ADDR_I == ADDR_FLASH_TRIGGER_CONFIG) ? trig_rd : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Output selection
    logic pwm_on;
    flr_pwm #(
        .PERIOD(PWM_PERIOD_CYC),
        .DUTY_W(PWM_DUTY_W)
    ) u_pwm (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .en_i(sink_en_reg && (mode_reg == MODE_INDICATOR)),
        .duty_i(INDICATOR_DUTY_I),
        .pwm_o(pwm_on)
    );

    wire ext_torch = (mode_reg == MODE_SHUTDOWN) && (EXT_TORCH_SEL_I == EXT_TORCH_SEL_ON);
    wire [7:0] code_sel = (mode_reg == MODE_INDICATOR) ? {2'h0, LED_CURRENT_I[5:0]} :
                          (mode_reg == MODE_ASSIST) ? {1'b0, LED_CURRENT_I[6:0]} :
                          (mode_reg == MODE_FLASH) ? LED_CURRENT_I :
                          ext_torch ? {1'b0, LED_CURRENT_I[6:0]} : 8'h00;
    wire active_sel = (mode_reg == MODE_INDICATOR) ? pwm_on :
                      (mode_reg == MODE_ASSIST) ? 1'b1 :
                      (mode_reg == MODE_FLASH) ? (state_reg == FS_FLASH) : ext_torch;
    wire sink_on = sink_en_reg;
    wire [7:0] code_out_next = sink_on ? code_sel : 8'h00;
    wire active_out_next = sink_on && active_sel;
    wire torch_out_next = sink_on && ext_torch;

    logic [7:0] code_out_reg;
    logic active_out_reg;
    logic torch_out_reg;
    logic sink_out_reg;
    logic flash_out_reg;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mode_reg <= MODE_RESET;
            sink_en_reg <= SINK_EN_RESET;
            trig_type_reg <= TRIG_TYPE_RESET;
            trig_en_reg <= TRIG_EN_RESET;
            trig_low_reg <= TRIG_LOW_RESET;
            rdata_reg <= 8'h00;
        end else begin
            mode_reg <= mode_next;
            sink_en_reg <= sink_en_next;
            rdata_reg <= rdata_next;
            if (wr_trig) begin
                trig_type_reg <= REG_WDATA_I[TRIG_TYPE_BIT];
                trig_en_reg <= REG_WDATA_I[TRIG_EN_BIT];
                trig_low_reg <= REG_WDATA_I[5:0];
            end
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_reg <= FS_IDLE;
            fcnt_reg <= '0;
            trig_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fcnt_reg <= fcnt_next;
            trig_prev_reg <= TRIGGER_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            code_out_reg <= 8'h00;
            active_out_reg <= 1'b0;
            torch_out_reg <= 1'b0;
            sink_out_reg <= 1'b0;
            flash_out_reg <= 1'b0;
        end else begin
            code_out_reg <= code_out_next;
            active_out_reg <= active_out_next;
            torch_out_reg <= torch_out_next;
            sink_out_reg <= sink_en_reg;
            flash_out_reg <= (state_reg == FS_FLASH);
        end
    end

    assign REG_RDATA_O = rdata_reg;
    assign SINK_EN_O = sink_out_reg;
    assign LED_CODE_O = code_out_reg;
    assign LED_ACTIVE_O = active_out_reg;
    assign EXT_TORCH_O = torch_out_reg;
    assign FLASH_ACTIVE_O = flash_out_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    // Light output in each operating mode
    a_shutdown_dark: assert property (
        (mode_reg == MODE_SHUTDOWN) && (EXT_TORCH_SEL_I != EXT_TORCH_SEL_ON)
        |=> !LED_ACTIVE_O && (LED_CODE_O == 8'h00)) else $error("Light on in shutdown");
    a_ext_torch_on: assert property (
        (mode_reg == MODE_SHUTDOWN) && sink_en_reg && (EXT_TORCH_SEL_I == EXT_TORCH_SEL_ON)
        |=> EXT_TORCH_O && LED_ACTIVE_O && (LED_CODE_O == {1'b0, $past(LED_CURRENT_I[6:0])})) else $error("No torch");
    a_torch_only_shutdown: assert property (
        mode_reg != MODE_SHUTDOWN
        |=> !EXT_TORCH_O) else $error("Torch outside shutdown");
    a_indicator_code: assert property (
        (mode_reg == MODE_INDICATOR) && sink_en_reg
        |=> LED_CODE_O == {2'h0, $past(LED_CURRENT_I[5:0])}) else $error("Indicator code wrong");
    a_indicator_pwm: assert property (
        (mode_reg == MODE_INDICATOR) && sink_en_reg
        |=> LED_ACTIVE_O == $past(pwm_on)) else $error("Indicator light not from PWM");
    a_assist_msb_cut: assert property (
        (mode_reg == MODE_ASSIST) && sink_en_reg
        |=> (LED_CODE_O == {1'b0, $past(LED_CURRENT_I[6:0])}) && LED_ACTIVE_O) else $error("Assist code wrong");
    a_assist_top_bit: assert property (
        mode_reg == MODE_ASSIST
        |=> !LED_CODE_O[7]) else $error("Assist uses top current bit");
    a_flash_full_code: assert property (
        (mode_reg == MODE_FLASH) && sink_en_reg
        |=> LED_CODE_O == $past(LED_CURRENT_I)) else $error("Flash code wrong");
    a_flash_light: assert property (
        (state_reg == FS_FLASH) && (mode_reg == MODE_FLASH) && sink_en_reg
        |=> LED_ACTIVE_O && FLASH_ACTIVE_O) else $error("Flash pulse dark");
    a_flash_dark_idle: assert property (
        (state_reg == FS_IDLE) && (mode_reg == MODE_FLASH)
        |=> !LED_ACTIVE_O && !FLASH_ACTIVE_O) else $error("Flash light before trigger");

    // Sink enable gating
    a_sink_gate: assert property (
        !sink_en_reg
        |=> !LED_ACTIVE_O && !EXT_TORCH_O && !SINK_EN_O) else $error("Sinks on while disabled");
    a_code_gate: assert property (
        !sink_en_reg
        |=> LED_CODE_O == 8'h00) else $error("Current code while disabled");
    a_sink_out_follow: assert property (
        1'b1
        |=> SINK_EN_O == $past(sink_en_reg)) else $error("Sink enable output lags");

    // Register access
    a_ctrl_write: assert property (
        wr_ctrl |=> (mode_reg == $past(REG_WDATA_I[CTRL_MODE_LSB+:2]))
        && (sink_en_reg == $past(REG_WDATA_I[CTRL_SINK_EN_BIT]))) else $error("Control write lost");
    a_trig_write: assert property (
        wr_trig |=> (trig_type_reg == $past(REG_WDATA_I[TRIG_TYPE_BIT]))
        && (trig_en_reg == $past(REG_WDATA_I[TRIG_EN_BIT]))) else $error("Trigger write lost");
    a_ctrl_hold: assert property (
        !wr_ctrl && !flash_end
        |=> $stable(mode_reg) && $stable(sink_en_reg)) else $error("Control changed without cause");
    a_trig_hold: assert property (
        !wr_trig
        |=> $stable(trig_type_reg) && $stable(trig_en_reg) && $stable(trig_low_reg)) else $error("Trigger changed");
    a_ctrl_readback: assert property (
        REG_ADDR_I == ADDR_OPERATING_CONTROL
        |=> REG_RDATA_O == {4'h0, $past(sink_en_reg), 1'b0, $past(mode_reg)}) else $error("Control read wrong");
    a_trig_readback: assert property (
        REG_ADDR_I == ADDR_FLASH_TRIGGER_CONFIG
        |=> REG_RDATA_O == {$past(trig_en_reg), $past(trig_type_reg), $past(trig_low_reg)})
        else $error("Trigger read wrong");
    a_unmapped_zero: assert property (
        (REG_ADDR_I != ADDR_OPERATING_CONTROL) && (REG_ADDR_I != ADDR_FLASH_TRIGGER_CONFIG)
        |=> REG_RDATA_O == 8'h00) else $error("Unmapped read nonzero");
    a_rsvd_zero: assert property (
        wr_ctrl ##1 REG_ADDR_I == ADDR_OPERATING_CONTROL
        |=> REG_RDATA_O[CTRL_RSVD_BIT] == 1'b0) else $error("Reserved bit read nonzero");

    // Flash sequencing
    a_flash_self_clear: assert property (
        flash_end && !wr_ctrl
        |=> (mode_reg == MODE_SHUTDOWN) && !sink_en_reg ##1 !SINK_EN_O) else $error("Flash did not clear");
    a_not_armed: assert property (
        !flash_sel
        |=> state_reg == FS_IDLE) else $error("Flash outside flash mode");
    a_trig_off_start: assert property (
        (state_reg == FS_IDLE) && flash_sel && !trig_en_reg
        |=> state_reg == FS_FLASH) else $error("Untriggered flash did not start");
    a_edge_start: assert property (
        (state_reg == FS_IDLE) && flash_sel && trig_en_reg && !trig_type_reg && trig_rise
        |=> state_reg == FS_FLASH ##1 FLASH_ACTIVE_O) else $error("Edge did not start flash");
    a_edge_needs_rise: assert property (
        (state_reg == FS_IDLE) && trig_en_reg && !trig_type_reg && !trig_rise
        |=> state_reg == FS_IDLE) else $error("Flash without edge");
    a_level_start: assert property (
        (state_reg == FS_IDLE) && flash_sel && trig_en_reg && trig_type_reg && TRIGGER_I
        |=> state_reg == FS_FLASH) else $error("Level trigger did not start flash");
    a_level_wait: assert property (
        (state_reg == FS_IDLE) && trig_en_reg && trig_type_reg && !TRIGGER_I
        |=> state_reg == FS_IDLE) else $error("Level flash without trigger");
    a_level_follow: assert property (
        (state_reg == FS_FLASH) && trig_en_reg && trig_type_reg && !TRIGGER_I
        |=> state_reg == FS_IDLE) else $error("Level flash outlived trigger");
    a_timeout_end: assert property (
        (state_reg == FS_FLASH) && flash_timeout
        |=> state_reg == FS_IDLE) else $error("Flash ran past timeout");
    a_flash_count: assert property (
        (state_reg == FS_FLASH) && flash_sel && !flash_end
        |=> fcnt_reg == $past(fcnt_reg) + 1'b1) else $error("Flash counter skipped");
    a_idle_count_zero: assert property (
        state_reg == FS_IDLE
        |-> fcnt_reg == '0) else $error("Flash counter not cleared");
    a_flash_bound: assert property (
        1'b1
        |-> 32'(fcnt_reg) < FLASH_CYCLES) else $error("Flash exceeded timeout");
    a_flash_out_follow: assert property (
        1'b1
        |=> FLASH_ACTIVE_O == $past(state_reg == FS_FLASH)) else $error("Flash output lags state");

    // Main scenarios
    c_indicator: cover property ((mode_reg == MODE_INDICATOR) && sink_en_reg ##1 LED_ACTIVE_O);
    c_edge_flash: cover property ((state_reg == FS_FLASH) && !trig_type_reg ##1 flash_end);
    c_level_drop: cover property ((state_reg == FS_FLASH) && level_drop);
    c_ext_torch: cover property (EXT_TORCH_O);
    c_flash_timeout: cover property ((state_reg == FS_FLASH) && flash_timeout);
endmodule
`default_nettype wire

// >>> rtl/flr_pkg.sv
// Constants for the flash LED operating control and trigger configuration registers
package flr_pkg;
    localparam logic [7:0] ADDR_OPERATING_CONTROL = 8'h06;
    localparam logic [7:0] ADDR_FLASH_TRIGGER_CONFIG = 8'h07;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RSVD_BIT = 2;
    localparam int CTRL_SINK_EN_BIT = 3;
    localparam int TRIG_TYPE_BIT = 6;
    localparam int TRIG_EN_BIT = 7;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic SINK_EN_RESET = 1'b0;
    localparam logic TRIG_TYPE_RESET = 1'b1;
    localparam logic TRIG_EN_RESET = 1'b1;
    localparam logic [5:0] TRIG_LOW_RESET = 6'h00;
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_INDICATOR = 2'h1;
    localparam logic [1:0] MODE_ASSIST = 2'h2;
    localparam logic [1:0] MODE_FLASH = 2'h3;
    localparam logic [1:0] EXT_TORCH_SEL_ON = 2'h2;
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int PWM_FREQ_HZ = 31_250;
    localparam int PWM_PERIOD_CYC = CLK_FREQ_HZ / PWM_FREQ_HZ;
    localparam int PWM_DUTY_W = 4;
    localparam int FLASH_TIME_MS = 72;
    localparam int FLASH_TIME_CYC = FLASH_TIME_MS * (CLK_FREQ_HZ / 1000);
    typedef enum logic {FS_IDLE, FS_FLASH} flr_flash_state_t;
endpackage

// >>> rtl/flr_pwm.sv
// Indicator PWM generator with a fixed period and sixteen duty steps
`timescale 1ns/1ns
`default_nettype none
module flr_pwm
    import flr_pkg::*;
#(
    parameter int PERIOD = PWM_PERIOD_CYC,
    parameter int DUTY_W = PWM_DUTY_W
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [DUTY_W-1:0] duty_i,
    output logic pwm_o
);
    localparam int CNT_W = $clog2(PERIOD);

    if (PERIOD < (2 ** DUTY_W) || (PERIOD % (2 ** DUTY_W)) != 0) begin : g_period_check
        $error("PWM period must be a multiple of the duty step count");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic pwm_reg;
    logic pwm_next;
    wire [31:0] thr = ((32'(duty_i) + 32'h1) * 32'(PERIOD)) >> DUTY_W;
    wire cnt_wrap = (32'(cnt_reg) == 32'(PERIOD - 1));

    assign cnt_next = (!en_i || cnt_wrap) ? '0 : cnt_reg + 1'b1;
    assign pwm_next = en_i && (32'(cnt_next) < thr);
    assign pwm_o = pwm_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            pwm_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            pwm_reg <= pwm_next;
        end
    end

    a_pwm_period: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        32'(cnt_reg) < PERIOD) else $error("PWM counter past period");
    a_pwm_off_idle: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !en_i |=> !pwm_reg) else $error("PWM active while disabled");
endmodule
`default_nettype wire

// >>> testbench/flr_trig_src.sv
// Flash trigger source model standing in for the camera host
`timescale 1ns/1ns
`default_nettype none
module flr_trig_src (
    input wire logic clk_i,
    input wire logic fire_i,
    input wire logic [2:0] delay_i,
    output logic trigger_o
);
    logic [7:0] sh_reg;
    // Delay 0 answers at once, larger values model a slow host
    always_ff @(posedge clk_i) begin
        sh_reg <= {sh_reg[6:0], fire_i};
    end
    assign trigger_o = (delay_i == 3'h0) ? fire_i : sh_reg[delay_i - 3'h1];
endmodule
`default_nettype wire

// >>> testbench/flr_regs_tb_top.sv
// Self-checking testbench for the operating control and trigger registers
`timescale 1ns/1ns
`default_nettype none
module flr_regs_tb_top
    import flr_pkg::*;
;
    localparam int FC = 20;
    logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, fire = 1'b0, trig;
    logic [7:0] addr = 8'h00, wdata = 8'h00, cur = 8'he5, rdata, code, cor;
    logic [3:0] duty = 4'h3;
    logic [1:0] tsel = 2'h0;
    logic [2:0] dly = 3'h0;
    logic sink, act, torch, fact;
    int err_total = 0;
    int compares = 0;
    int cnt;
    logic [7:0] tv[4] = '{8'h0a, 8'h08, 8'h08, 8'h02};
    logic [1:0] ts[4] = '{2'h0, 2'h2, 2'h1, 2'h0};
    logic [7:0] tc[4] = '{8'h65, 8'h65, 8'h00, 8'h00};
    logic tt[4] = '{1'b0, 1'b1, 1'b0, 1'b0};

    flr_regs #(.FLASH_CYCLES(FC)) DUT (.CLK_I(clk), .RST_N_I(rst_n), .REG_WE_I(we), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .LED_CURRENT_I(cur), .INDICATOR_DUTY_I(duty),
        .EXT_TORCH_SEL_I(tsel), .TRIGGER_I(trig), .SINK_EN_O(sink), .LED_CODE_O(code),
        .LED_ACTIVE_O(act), .EXT_TORCH_O(torch), .FLASH_ACTIVE_O(fact));
    flr_trig_src u_trig (.clk_i(clk), .fire_i(fire), .delay_i(dly), .trigger_o(trig));

    initial begin
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 we = 1'b1;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 we = 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        #1 addr = a;
        @(posedge clk);
        #1 chk(what, rdata, exp);
    endtask
    // Counts active cycles of the chosen output and ORs together every code seen
    task automatic measure(input int n, input bit sel);
        cnt = 0;
        cor = 8'h00;
        repeat (n) begin
            @(posedge clk);
            #1 cnt += (sel ? act : fact) === 1'b1;
            cor |= code;
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        rdchk(8'h06, 8'h00, "ctrl reset");
        rdchk(8'h07, 8'hc0, "trig reset");
        wr(8'h07, 8'h95);
        rdchk(8'h07, 8'h95, "trig rw");
        wr(8'h05, 8'hff);
        rdchk(8'h05, 8'h00, "unmapped");
        rdchk(8'h06, 8'h00, "ctrl kept");
        wr(8'h06, 8'hf9);
        rdchk(8'h06, 8'h09, "ctrl rw");
        chk("indicator code", code, 8'h25);
        for (int i = 0; i < 4; i++) begin
            tsel = ts[i];
            wr(8'h06, tv[i]);
            repeat (2) @(posedge clk);
            #1 chk("mode code", code, tc[i]);
            chk("torch", torch, tt[i]);
            chk("sink", sink, tv[i][3]);
        end
        tsel = 2'h0;
        wr(8'h06, 8'h09);
        repeat (10) @(posedge clk);
        measure(3200, 1'b1);
        chk("pwm on time", cnt, 800);
        wr(8'h06, 8'h00);
        wr(8'h07, 8'h80);
        wr(8'h06, 8'h0b);
        measure(8, 1'b0);
        chk("flash unarmed", cnt, 0);
        dly = 3'h3;
        fire = 1'b1;
        measure(40, 1'b0);
        chk("edge flash len", cnt, FC);
        chk("flash code", cor, 8'he5);
        rdchk(8'h06, 8'h00, "self clear");
        chk("sink cleared", sink, 1'b0);
        fire = 1'b0;
        repeat (5) @(posedge clk);
        #1 fire = 1'b1;
        measure(30, 1'b0);
        chk("no rearm", cnt, 0);
        fire = 1'b0;
        dly = 3'h0;
        wr(8'h07, 8'hc0);
        wr(8'h06, 8'h0b);
        fork
            begin
                fire = 1'b1;
                repeat (5) @(posedge clk);
                #1 fire = 1'b0;
            end
            measure(40, 1'b0);
        join
        chk("level short", cnt, 5);
        wr(8'h06, 8'h0b);
        fire = 1'b1;
        measure(40, 1'b0);
        chk("level bound", cnt, FC);
        fire = 1'b0;
        wr(8'h07, 8'h00);
        wr(8'h06, 8'h0b);
        measure(40, 1'b0);
        chk("trig off flash", cnt, FC);
        summarize();
    end
endmodule
`default_nettype wire
